// *** tbs_pkg.sv ***
package tbs_pkg;

    localparam int          IR_WIDTH       = 3;
    localparam int          ID_WIDTH       = 32;

    // Instruction codes; any code not listed here selects the bypass bit.
    localparam logic [2:0]  OP_EXTEST      = 3'h0;
    localparam logic [2:0]  OP_SAMPLE      = 3'h1;
    localparam logic [2:0]  OP_IDCODE      = 3'h2;
    localparam logic [2:0]  OP_BYPASS      = 3'h7;

    // Pattern loaded into the instruction path on capture: low two bits 01.
    localparam logic [2:0]  IR_CAPTURE     = 3'h1;
    localparam logic [2:0]  IR_RESET       = OP_IDCODE;
    localparam logic        BYPASS_RESET   = 1'h0;
    localparam logic        TDO_RESET      = 1'h0;

    // Identification word; the value is arbitrary, bit 0 must stay set.
    localparam logic [31:0] ID_DEFAULT     = 32'h0000_0F01;

    // Sampling period of the test clock as seen by CLK, for reference.
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          TCK_MIN_NS     = 80;
    localparam int          TCK_MIN_CYCLES = (TCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } tbs_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tbs_pins_t;

endpackage : tbs_pkg

// *** tbs_shreg.sv ***
`timescale 1ns/1ps
`default_nettype none

// Capture/shift/update cell chain, shifting toward bit 0.
module tbs_shreg #(
    parameter int                WIDTH       = 8,
    parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             capture,
    input  wire logic             shift,
    input  wire logic             update,
    input  wire logic             serial_in,
    input  wire logic [WIDTH-1:0] parallel_in,
    output logic                  serial_out,
    output logic [WIDTH-1:0]      parallel_out
);

    logic [WIDTH-1:0] chain;
    logic [WIDTH-1:0] next_chain;
    logic [WIDTH-1:0] next_parallel_out;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("tbs_shreg needs WIDTH of at least one");
        end
    endgenerate

    always_comb
    begin
        next_chain        = chain;
        next_parallel_out = parallel_out;
        if (capture)
        begin
            next_chain = parallel_in;
        end
        else if (shift)
        begin
            if (WIDTH == 1)
            begin
                next_chain = {WIDTH{serial_in}};
            end
            else
            begin
                next_chain = {serial_in, chain[WIDTH-1:1]};
            end
        end
        if (update)
        begin
            next_parallel_out = chain;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chain        <= RESET_VALUE;
            parallel_out <= RESET_VALUE;
        end
        else
        begin
            chain        <= next_chain;
            parallel_out <= next_parallel_out;
        end
    end

    assign serial_out = chain[0];

endmodule : tbs_shreg

`default_nettype wire

// *** tbs_tap.sv ***
// Behaviour
// - Test mode select is sampled at each test clock rise and steers the controller.
// - Test data input is sampled at each test clock rise.
// - Test data output changes only at test clock falls.
// - Test data output is undriven except while a scan path shifts.
// - Active-low test reset resets the port at once, without a clock edge.
`timescale 1ns/1ps
`default_nettype none

module tbs_tap #(
    parameter int                 BSR_LEN = 16,
    parameter logic [31:0]        ID_CODE = tbs_pkg::ID_DEFAULT
) (
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire logic               TEST_CLK,
    input  wire logic               TEST_MODE_SEL,
    input  wire logic               TEST_DATA_IN,
    input  wire logic               TEST_RESET_N,
    input  wire logic [BSR_LEN-1:0] BSR_CAPTURE_IN,
    output logic [BSR_LEN-1:0]      BSR_UPDATE_OUT,
    output logic                    EXTEST_ACTIVE,
    output logic                    TEST_DATA_OUT,
    output logic                    TEST_DATA_OE
);

    tbs_pkg::tbs_pins_t  pins_meta;
    tbs_pkg::tbs_pins_t  pins_sync;
    logic                tck_prev;
    logic                tck_rise;
    logic                tck_fall;
    logic                tap_rst;

    tbs_pkg::tbs_state_t state;
    tbs_pkg::tbs_state_t next_state;
    logic                bypass_bit;
    logic                next_bypass_bit;
    logic                next_tdo;
    logic                next_oe;
    logic                next_extest;
    logic                ir_clear;
    logic                next_ir_clear;

    logic [tbs_pkg::IR_WIDTH-1:0] ir_value;
    logic                         ir_out;
    logic                         id_out;
    logic                         bsr_out;
    logic                         sel_id;
    logic                         sel_bsr;
    logic                         shift_mux;

    generate
        if (BSR_LEN < 1 || ID_CODE[0] != 1'b1)
        begin : g_bad_param
            $error("tbs_tap needs BSR_LEN >= 1 and ID_CODE bit 0 set");
        end
    endgenerate

    // test reset
    // The pin clears the port directly, so no test clock edge is needed.
    assign tap_rst = RESET | ~TEST_RESET_N;

    // Clock, mode select and data in come through two flops; the edge detector reads the second and its copy one cycle later.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pins_meta <= '0;
            pins_sync <= '0;
            tck_prev  <= 1'b0;
        end
        else
        begin
            pins_meta <= '{tck: TEST_CLK, tms: TEST_MODE_SEL, tdi: TEST_DATA_IN};
            pins_sync <= pins_meta;
            tck_prev  <= pins_sync.tck;
        end
    end

    assign tck_rise = pins_sync.tck & ~tck_prev;
    assign tck_fall = ~pins_sync.tck & tck_prev;

    always_comb
    begin
        next_state = state;
        if (tck_rise)
        begin
            case (state)
                tbs_pkg::ST_RESET:    next_state = pins_sync.tms ? tbs_pkg::ST_RESET    : tbs_pkg::ST_IDLE;
                tbs_pkg::ST_IDLE:     next_state = pins_sync.tms ? tbs_pkg::ST_SEL_DR   : tbs_pkg::ST_IDLE;
                tbs_pkg::ST_SEL_DR:   next_state = pins_sync.tms ? tbs_pkg::ST_SEL_IR   : tbs_pkg::ST_CAP_DR;
                tbs_pkg::ST_CAP_DR:   next_state = pins_sync.tms ? tbs_pkg::ST_EXIT1_DR : tbs_pkg::ST_SHIFT_DR;
                tbs_pkg::ST_SHIFT_DR: next_state = pins_sync.tms ? tbs_pkg::ST_EXIT1_DR : tbs_pkg::ST_SHIFT_DR;
                tbs_pkg::ST_EXIT1_DR: next_state = pins_sync.tms ? tbs_pkg::ST_UPD_DR   : tbs_pkg::ST_PAUSE_DR;
                tbs_pkg::ST_PAUSE_DR: next_state = pins_sync.tms ? tbs_pkg::ST_EXIT2_DR : tbs_pkg::ST_PAUSE_DR;
                tbs_pkg::ST_EXIT2_DR: next_state = pins_sync.tms ? tbs_pkg::ST_UPD_DR   : tbs_pkg::ST_SHIFT_DR;
                tbs_pkg::ST_UPD_DR:   next_state = pins_sync.tms ? tbs_pkg::ST_SEL_DR   : tbs_pkg::ST_IDLE;
                tbs_pkg::ST_SEL_IR:   next_state = pins_sync.tms ? tbs_pkg::ST_RESET    : tbs_pkg::ST_CAP_IR;
                tbs_pkg::ST_CAP_IR:   next_state = pins_sync.tms ? tbs_pkg::ST_EXIT1_IR : tbs_pkg::ST_SHIFT_IR;
                tbs_pkg::ST_SHIFT_IR: next_state = pins_sync.tms ? tbs_pkg::ST_EXIT1_IR : tbs_pkg::ST_SHIFT_IR;
                tbs_pkg::ST_EXIT1_IR: next_state = pins_sync.tms ? tbs_pkg::ST_UPD_IR   : tbs_pkg::ST_PAUSE_IR;
                tbs_pkg::ST_PAUSE_IR: next_state = pins_sync.tms ? tbs_pkg::ST_EXIT2_IR : tbs_pkg::ST_PAUSE_IR;
                tbs_pkg::ST_EXIT2_IR: next_state = pins_sync.tms ? tbs_pkg::ST_UPD_IR   : tbs_pkg::ST_SHIFT_IR;
                tbs_pkg::ST_UPD_IR:   next_state = pins_sync.tms ? tbs_pkg::ST_SEL_DR   : tbs_pkg::ST_IDLE;
                default:              next_state = tbs_pkg::ST_RESET;
            endcase
        end
    end

    assign sel_id  = (ir_value == tbs_pkg::OP_IDCODE);
    assign sel_bsr = (ir_value == tbs_pkg::OP_EXTEST) || (ir_value == tbs_pkg::OP_SAMPLE);

    always_comb
    begin
        if (state == tbs_pkg::ST_SHIFT_IR)
        begin
            shift_mux = ir_out;
        end
        else if (sel_id)
        begin
            shift_mux = id_out;
        end
        else if (sel_bsr)
        begin
            shift_mux = bsr_out;
        end
        else
        begin
            shift_mux = bypass_bit;
        end
    end

    always_comb
    begin
        next_bypass_bit = bypass_bit;
        next_tdo        = TEST_DATA_OUT;
        next_oe         = TEST_DATA_OE;
        next_extest     = (ir_value == tbs_pkg::OP_EXTEST);
        // A decoded state never drives a reset pin directly, since a glitch would clear the instruction.
        next_ir_clear   = (next_state == tbs_pkg::ST_RESET);
        if (tck_rise && state == tbs_pkg::ST_CAP_DR)
        begin
            next_bypass_bit = 1'b0;
        end
        else if (tck_rise && state == tbs_pkg::ST_SHIFT_DR)
        begin
            next_bypass_bit = pins_sync.tdi;
        end
        if (tck_fall)
        begin
            next_tdo = shift_mux;
            next_oe  = (state == tbs_pkg::ST_SHIFT_DR) || (state == tbs_pkg::ST_SHIFT_IR);
        end
    end

    always_ff @(posedge CLK or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            state         <= tbs_pkg::ST_RESET;
            bypass_bit    <= tbs_pkg::BYPASS_RESET;
            TEST_DATA_OUT <= tbs_pkg::TDO_RESET;
            TEST_DATA_OE  <= 1'b0;
            EXTEST_ACTIVE <= 1'b0;
            ir_clear      <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            bypass_bit    <= next_bypass_bit;
            TEST_DATA_OUT <= next_tdo;
            TEST_DATA_OE  <= next_oe;
            EXTEST_ACTIVE <= next_extest;
            ir_clear      <= next_ir_clear;
        end
    end

    // instruction register
    // Update happens on the fall inside the update state, as the standard asks.
    tbs_shreg #(
        .WIDTH       (tbs_pkg::IR_WIDTH),
        .RESET_VALUE (tbs_pkg::IR_RESET)
    ) u_ir (
        .clk          (CLK),
        .rst          (tap_rst | ir_clear),
        .capture      (tck_rise && state == tbs_pkg::ST_CAP_IR),
        .shift        (tck_rise && state == tbs_pkg::ST_SHIFT_IR),
        .update       (tck_fall && state == tbs_pkg::ST_UPD_IR),
        .serial_in    (pins_sync.tdi),
        .parallel_in  (tbs_pkg::IR_CAPTURE),
        .serial_out   (ir_out),
        .parallel_out (ir_value)
    );

    tbs_shreg #(
        .WIDTH       (tbs_pkg::ID_WIDTH),
        .RESET_VALUE (ID_CODE)
    ) u_id (
        .clk          (CLK),
        .rst          (tap_rst),
        .capture      (tck_rise && sel_id && state == tbs_pkg::ST_CAP_DR),
        .shift        (tck_rise && sel_id && state == tbs_pkg::ST_SHIFT_DR),
        .update       (1'b0),
        .serial_in    (pins_sync.tdi),
        .parallel_in  (ID_CODE),
        .serial_out   (id_out),
        .parallel_out ()
    );

    // boundary path
    // Update outputs hold their value through a test reset of the controller only
    // if RESET stays low and TEST_RESET_N stays high; both clear them, trading hold for safety.
    tbs_shreg #(
        .WIDTH       (BSR_LEN),
        .RESET_VALUE ('0)
    ) u_bsr (
        .clk          (CLK),
        .rst          (tap_rst),
        .capture      (tck_rise && sel_bsr && state == tbs_pkg::ST_CAP_DR),
        .shift        (tck_rise && sel_bsr && state == tbs_pkg::ST_SHIFT_DR),
        .update       (tck_fall && sel_bsr && state == tbs_pkg::ST_UPD_DR),
        .serial_in    (pins_sync.tdi),
        .parallel_in  (BSR_CAPTURE_IN),
        .serial_out   (bsr_out),
        .parallel_out (BSR_UPDATE_OUT)
    );

endmodule : tbs_tap

`default_nettype wire

// *** tbs_tap_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module tbs_tap_props #(
    parameter int BSR_LEN = 16
) (
    input wire logic               CLK,
    input wire logic               RESET,
    input wire logic               TEST_CLK,
    input wire logic               TEST_MODE_SEL,
    input wire logic               TEST_DATA_IN,
    input wire logic               TEST_RESET_N,
    input wire logic [BSR_LEN-1:0] BSR_CAPTURE_IN,
    input wire logic [BSR_LEN-1:0] BSR_UPDATE_OUT,
    input wire logic               EXTEST_ACTIVE,
    input wire logic               TEST_DATA_OUT,
    input wire logic               TEST_DATA_OE
);
    logic       last_tms;
    logic [2:0] ones;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET || !TEST_RESET_N);

    // Pin-level view of the last test clock rise, independent of the design's sampler.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            last_tms <= 1'h1;
            ones     <= 3'h0;
        end
        else if ($rose(TEST_CLK))
        begin
            last_tms <= TEST_MODE_SEL;
            ones     <= !TEST_MODE_SEL ? 3'h0 : (ones == 3'h5) ? ones : ones + 3'h1;
        end
    end

    a_tdo_at_fall: assert property ($changed(TEST_DATA_OUT) |-> !$past(TEST_CLK, 2))
        else $error("data out changed while test clock high");
    a_oe_at_fall: assert property ($changed(TEST_DATA_OE) |-> !$past(TEST_CLK, 2))
        else $error("output enable changed while test clock high");
    a_oe_shift_only: assert property ($rose(TEST_DATA_OE) |-> !last_tms)
        else $error("output enable rose outside a shift entry");
    a_tms_reset_walk: assert property ($rose(ones == 3'h5) |-> ##[1:8] !EXTEST_ACTIVE)
        else $error("five mode-select ones did not reset the instruction");
    a_test_reset_async: assert property (@(posedge CLK) disable iff (RESET)
        !TEST_RESET_N |-> !TEST_DATA_OE && !EXTEST_ACTIVE && !TEST_DATA_OUT)
        else $error("test reset did not clear the port outputs");
    a_update_at_fall: assert property ($changed(BSR_UPDATE_OUT) |-> !$past(TEST_CLK, 2))
        else $error("boundary update changed while test clock high");
    a_extest_at_fall: assert property ($rose(EXTEST_ACTIVE) |-> !$past(TEST_CLK, 2))
        else $error("instruction changed while test clock high");

    c_shift: cover property ($rose(TEST_DATA_OE));
    c_extest: cover property ($rose(EXTEST_ACTIVE));
    c_test_reset: cover property (@(posedge CLK) disable iff (RESET) $fell(TEST_RESET_N));
endmodule : tbs_tap_props

bind tbs_tap tbs_tap_props #(.BSR_LEN(BSR_LEN)) i_props (
    .CLK(CLK), .RESET(RESET), .TEST_CLK(TEST_CLK), .TEST_MODE_SEL(TEST_MODE_SEL),
    .TEST_DATA_IN(TEST_DATA_IN), .TEST_RESET_N(TEST_RESET_N),
    .BSR_CAPTURE_IN(BSR_CAPTURE_IN), .BSR_UPDATE_OUT(BSR_UPDATE_OUT),
    .EXTEST_ACTIVE(EXTEST_ACTIVE), .TEST_DATA_OUT(TEST_DATA_OUT), .TEST_DATA_OE(TEST_DATA_OE)
);

`default_nettype wire

// *** tbs_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module tbs_ctrl_model (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo,
    input  wire logic oe
);
    logic last_bit;
    logic oe_rise;

    initial
    begin
        tck      = 1'h0;
        tms      = 1'h1;
        tdi      = 1'h1;
        trst_n   = 1'h0;
        last_bit = 1'h0;
        oe_rise  = 1'h0;
    end

    task automatic hold_reset(input logic v);
        trst_n = v;
    endtask : hold_reset

    // One 80 ns test clock period; the released data out reads as the inverse of its last bit.
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck      = 1'h1;
        oe_rise  = oe;
        q        = oe ? tdo : ~last_bit;
        last_bit = q;
        repeat (4) @(negedge clk);
        tck = 1'h0;
    endtask : tick

    task automatic goto_reset();
        logic q;
        repeat (5) tick(1'h1, 1'h1, q);
        tick(1'h0, 1'h1, q);
    endtask : goto_reset

    // Walks Idle to Shift, shifts n bits LSB first, then Update and back to Idle.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout, output logic all_oe);
        logic q;
        dout   = '0;
        all_oe = 1'h1;
        tick(1'h1, 1'h1, q);
        if (ir)
            tick(1'h1, 1'h1, q);
        tick(1'h0, 1'h1, q);
        tick(1'h0, 1'h1, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
            all_oe  = all_oe & oe_rise;
        end
        tick(1'h1, 1'h1, q);
        tick(1'h0, 1'h1, q);
        tms = 1'h1;
        tdi = 1'h1;
    endtask : scan
endmodule : tbs_ctrl_model

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        CLK, RESET, TEST_CLK, TEST_MODE_SEL, TEST_DATA_IN, TEST_RESET_N;
    logic [15:0] BSR_CAPTURE_IN, BSR_UPDATE_OUT;
    logic        EXTEST_ACTIVE, TEST_DATA_OUT, TEST_DATA_OE, all_oe, q;
    logic [63:0] dout;
    int          fail_count, compares, cycles;

    tbs_tap #(.BSR_LEN(16)) i_dut (
        .CLK(CLK), .RESET(RESET), .TEST_CLK(TEST_CLK), .TEST_MODE_SEL(TEST_MODE_SEL),
        .TEST_DATA_IN(TEST_DATA_IN), .TEST_RESET_N(TEST_RESET_N),
        .BSR_CAPTURE_IN(BSR_CAPTURE_IN), .BSR_UPDATE_OUT(BSR_UPDATE_OUT),
        .EXTEST_ACTIVE(EXTEST_ACTIVE), .TEST_DATA_OUT(TEST_DATA_OUT), .TEST_DATA_OE(TEST_DATA_OE));
    tbs_ctrl_model i_ctrl (.clk(CLK), .tck(TEST_CLK), .tms(TEST_MODE_SEL), .tdi(TEST_DATA_IN),
        .trst_n(TEST_RESET_N), .tdo(TEST_DATA_OUT), .oe(TEST_DATA_OE));

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic results();
        $display("errors %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic t_idcode();
        i_ctrl.goto_reset();
        i_ctrl.scan(1'h0, 32, 64'h0, dout, all_oe);
        check(dout[31:0], tbs_pkg::ID_DEFAULT, "identification word");
        check(all_oe, 1'h1, "enable while shifting");
        check(TEST_DATA_OE, 1'h0, "enable after scan");
    endtask : t_idcode

    task automatic t_bypass();
        logic [2:0] codes [2] = '{tbs_pkg::OP_BYPASS, 3'h4};
        foreach (codes[k])
        begin
            i_ctrl.scan(1'h1, 3, {61'h0, codes[k]}, dout, all_oe);
            check(dout[2:0], tbs_pkg::IR_CAPTURE, "instruction capture");
            i_ctrl.scan(1'h0, 6, 64'h2D, dout, all_oe);
            check(dout[5:0], 6'h1A, "bypass delay");
        end
    endtask : t_bypass

    task automatic t_sample();
        i_ctrl.scan(1'h1, 3, {61'h0, tbs_pkg::OP_SAMPLE}, dout, all_oe);
        check(EXTEST_ACTIVE, 1'h0, "sample is not extest");
        i_ctrl.scan(1'h0, 16, 64'hA5C3, dout, all_oe);
        check(dout[15:0], 16'h3C96, "boundary capture");
        check(BSR_UPDATE_OUT, 16'hA5C3, "boundary update");
    endtask : t_sample

    task automatic t_extest_tms_reset();
        i_ctrl.scan(1'h1, 3, {61'h0, tbs_pkg::OP_EXTEST}, dout, all_oe);
        check(EXTEST_ACTIVE, 1'h1, "extest loaded");
        i_ctrl.goto_reset();
        check(EXTEST_ACTIVE, 1'h0, "mode select reset");
    endtask : t_extest_tms_reset

    task automatic t_test_reset();
        i_ctrl.scan(1'h1, 3, {61'h0, tbs_pkg::OP_EXTEST}, dout, all_oe);
        i_ctrl.tick(1'h1, 1'h1, q);
        repeat (3) i_ctrl.tick(1'h0, 1'h1, q);
        check(TEST_DATA_OE, 1'h1, "enable in shift");
        i_ctrl.hold_reset(1'h0);
        #1;
        check({TEST_DATA_OE, EXTEST_ACTIVE, BSR_UPDATE_OUT}, 64'h0, "async test reset");
        @(negedge CLK);
        i_ctrl.hold_reset(1'h1);
        @(negedge CLK);
        i_ctrl.tick(1'h0, 1'h1, q);
        i_ctrl.scan(1'h0, 32, 64'h0, dout, all_oe);
        check(dout[31:0], tbs_pkg::ID_DEFAULT, "instruction after test reset");
    endtask : t_test_reset

    // Shift one bit, park in the pause state, resume and shift the second bit.
    task automatic t_pause();
        logic [1:0] bits;
        i_ctrl.tick(1'h1, 1'h1, q);
        repeat (2) i_ctrl.tick(1'h0, 1'h1, q);
        i_ctrl.tick(1'h1, 1'h1, bits[0]);
        i_ctrl.tick(1'h0, 1'h1, q);
        check(TEST_DATA_OE, 1'h0, "enable in pause");
        i_ctrl.tick(1'h1, 1'h1, q);
        i_ctrl.tick(1'h0, 1'h1, q);
        i_ctrl.tick(1'h1, 1'h1, bits[1]);
        i_ctrl.tick(1'h1, 1'h1, q);
        i_ctrl.tick(1'h0, 1'h1, q);
        check(bits, tbs_pkg::ID_DEFAULT[1:0], "shift across pause");
    endtask : t_pause

    initial
    begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end

    initial
    begin
        RESET          = 1'h1;
        BSR_CAPTURE_IN = 16'h3C96;
        repeat (5) @(negedge CLK);
        RESET = 1'h0;
        i_ctrl.hold_reset(1'h1);
        @(negedge CLK);
        check({TEST_DATA_OE, EXTEST_ACTIVE, BSR_UPDATE_OUT}, 64'h0, "outputs after reset");
        t_idcode();
        t_bypass();
        t_sample();
        t_extest_tms_reset();
        t_test_reset();
        t_pause();
        results();
    end
endmodule : testbench

`default_nettype wire
